// >>> rtl/pelr_map.vh
`ifndef PELR_MAP_VH
`define PELR_MAP_VH

// register indices; byte address is four times the index
`define PELR_IDX_SEL_FIRST   20'hf0300
`define PELR_IDX_SEL_LAST    20'hf0309
`define PELR_IDX_STATUS      20'hf030a

// selection register layout
`define PELR_SEL_WIDTH       8
`define PELR_SEL_RESET       8'h00
`define PELR_DEST_LSB        0
`define PELR_DEST_MSB        1

// destination field codes
`define PELR_DEST_OFF        2'h0
`define PELR_DEST_ADC        2'h1
`define PELR_DEST_DAC0       2'h2
`define PELR_DEST_DAC1       2'h3

// status register layout
`define PELR_STAT_SEEN_LSB   0
`define PELR_STAT_SEEN_MSB   9
`define PELR_STAT_CLASH_LSB  16
`define PELR_STAT_CLASH_MSB  18
`define PELR_STAT_RESET      32'h00000000

// timing: d/a real-time start lag in cpu clock cycles (2 or 3 allowed)
`define PELR_CLK_PERIOD_NS   25
`define PELR_DAC_LAG_CYCLES  2

// axi response codes
`define PELR_RESP_OKAY       2'h0
`define PELR_RESP_SLVERR     2'h2

`endif

// >>> rtl/pelr_sel_reg.v
`timescale 1ns/1ps
`include "pelr_map.vh"

module pelr_sel_reg (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rstn,
   // register access
   input  wire       writeEn,
   input  wire [7:0] writeData,
   output wire [7:0] readData,
   // event routing
   input  wire       eventIn,
   output reg        routeAdc,
   output reg        routeDac0,
   output reg        routeDac1
);

   reg [1:0] dest_reg;

   // only the destination field is stored
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dest_reg <= `PELR_DEST_OFF; // reset leaves the link disabled
      end else if (writeEn) begin
         dest_reg <= writeData[`PELR_DEST_MSB:`PELR_DEST_LSB];
      end
   end

   // upper six bits are constant zero
   assign readData = {6'h00, dest_reg};

   // decode field into one receiver; disabled code matches none
   always @* begin
      routeAdc  = 1'b0;
      routeDac0 = 1'b0;
      routeDac1 = 1'b0;
      case (dest_reg)
         `PELR_DEST_ADC:  routeAdc  = eventIn;
         `PELR_DEST_DAC0: routeDac0 = eventIn;
         `PELR_DEST_DAC1: routeDac1 = eventIn;
         default: begin
            routeAdc = 1'b0;
         end
      endcase
   end

endmodule

// >>> rtl/pelr_router.v
`timescale 1ns/1ps
`include "pelr_map.vh"

// What this block does
// - Each event source has its own selection register that steers its pulse to one receiver action.
// - A selection register is eight bits wide, with the destination in bits 1:0 and zeros above.
// - Destination code 0 disables, 1 starts a/d conversion, 2 fires d/a channel 0, 3 fires d/a channel 1.
// - Selection registers 0 to 5 serve the six pin edge detectors in that order.
// - Selection registers 6 to 9 serve the end events of timer channels 0 to 3 in that order.
// - Routing is independent of any interrupt flag or enable of the source.
// - An event routed to the a/d converter is its hardware conversion trigger directly.
// - An event routed to a d/a channel starts its conversion 2 or 3 cpu clocks after the event.
// - One cycle of response timing is one cpu clock period.

module pelr_router #(
   parameter NUM_SRC = 10
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rstn,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   output wire [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [31:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   // axi4-lite read data
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   // pin edge detector events, one-cycle pulses
   input  wire        pinEdgeEvent0,
   input  wire        pinEdgeEvent1,
   input  wire        pinEdgeEvent2,
   input  wire        pinEdgeEvent3,
   input  wire        pinEdgeEvent4,
   input  wire        pinEdgeEvent5,
   // timer channel count or capture end events
   input  wire        timerCh0EndEvent,
   input  wire        timerCh1EndEvent,
   input  wire        timerCh2EndEvent,
   input  wire        timerCh3EndEvent,
   // receiver triggers
   output wire        adcConvStart,
   output wire        dacChannelZeroStart,
   output wire        dacChannelOneStart
);

   // d/a start lag; 2 or 3 keeps the start inside the allowed window
   localparam LAG = `PELR_DAC_LAG_CYCLES;

   // each handshake half is parked here until its partner arrives
   // write channel state
   reg        awHeld_reg;
   reg [31:0] awAddr_reg;
   reg        wHeld_reg;
   reg [31:0] wData_reg;
   reg [3:0]  wStrb_reg;
   reg        bValid_reg;
   reg [1:0]  bResp_reg;
   // read channel state
   reg        rValid_reg;
   reg [31:0] rData_reg;
   reg [1:0]  rResp_reg;
   // status and d/a lag lines
   reg [9:0]  seen_reg;
   reg [9:0]  seen_next;
   reg [LAG-1:0] dac0Pipe_reg;
   reg [LAG-1:0] dac1Pipe_reg;

   // per-source routing, read-back and receiver usage counts
   wire [NUM_SRC-1:0]   srcEvent;
   wire [NUM_SRC-1:0]   toAdc;
   wire [NUM_SRC-1:0]   toDac0;
   wire [NUM_SRC-1:0]   toDac1;
   wire [NUM_SRC*8-1:0] selRead;
   wire [NUM_SRC-1:0]   selWe;
   reg  [2:0]           clash;
   reg  [1:0]           cntAdc;
   reg  [1:0]           cntDac0;
   reg  [1:0]           cntDac1;
   integer              k;
   reg  [7:0]           rSelByte;
   reg  [31:0]          statWord;
   integer              r;

   // sources enter in register order, pins first then timers
   assign srcEvent = {timerCh3EndEvent, timerCh2EndEvent,
                      timerCh1EndEvent, timerCh0EndEvent,
                      pinEdgeEvent5, pinEdgeEvent4,
                      pinEdgeEvent3, pinEdgeEvent2,
                      pinEdgeEvent1, pinEdgeEvent0};

   // ------------------------------------------------------------ write path
   // a write commits one cycle after the later of its two halves
   // protection attributes on both address channels are accepted and ignored
   wire        doWrite  = awHeld_reg && wHeld_reg && !bValid_reg;
   wire [29:0] wIdx     = awAddr_reg[31:2];
   wire [29:0] wRel     = wIdx - {10'h000, `PELR_IDX_SEL_FIRST};
   wire        wSelHit  = (wIdx >= {10'h000, `PELR_IDX_SEL_FIRST}) &&
                          (wIdx <= {10'h000, `PELR_IDX_SEL_LAST});
   wire        wStatHit = (wIdx == {10'h000, `PELR_IDX_STATUS});
   wire [15:0] wOneHot  = 16'h0001 << wRel[3:0];

   // byte lane 0 carries the whole selection register
   assign selWe = (doWrite && wSelHit && wStrb_reg[0]) ? wOneHot[NUM_SRC-1:0] : {NUM_SRC{1'b0}};

   // each channel is taken once and held until the pair completes
   assign s_axi_awready = !awHeld_reg && !bValid_reg;
   assign s_axi_wready  = !wHeld_reg && !bValid_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;

   // address and data may arrive in either order
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= 32'h00000000;
         wHeld_reg  <= 1'b0;
         wData_reg  <= 32'h00000000;
         wStrb_reg  <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg  <= `PELR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         // commit frees both halves; a new pair waits for the answer to go
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg  <= (wSelHit || wStatHit) ? `PELR_RESP_OKAY : `PELR_RESP_SLVERR;
         end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------ read path
   // read decode runs straight off the address bus; the answer is registered
   wire [29:0] rIdx     = s_axi_araddr[31:2];
   wire [29:0] rRel     = rIdx - {10'h000, `PELR_IDX_SEL_FIRST};
   wire        rSelHit  = (rIdx >= {10'h000, `PELR_IDX_SEL_FIRST}) &&
                          (rIdx <= {10'h000, `PELR_IDX_SEL_LAST});
   wire        rStatHit = (rIdx == {10'h000, `PELR_IDX_STATUS});

   // pick the addressed selector by compare, never by an index past the last slot
   always @* begin
      rSelByte = 8'h00;
      for (r = 0; r < NUM_SRC; r = r + 1) begin
         if (rRel[3:0] == r[3:0]) begin
            rSelByte = selRead[r*8 +: 8];
         end
      end
   end

   // status word: sticky routed flags low, live clash flags from bit 16
   always @* begin
      statWord = `PELR_STAT_RESET;
      statWord[`PELR_STAT_SEEN_MSB:`PELR_STAT_SEEN_LSB]   = seen_reg;
      statWord[`PELR_STAT_CLASH_MSB:`PELR_STAT_CLASH_LSB] = clash;
   end

   // one read in flight; a new address waits until the data is taken
   assign s_axi_arready = !rValid_reg;
   assign s_axi_rvalid  = rValid_reg;
   assign s_axi_rdata   = rData_reg;
   assign s_axi_rresp   = rResp_reg;

   // data sampled at the address handshake, answered next cycle
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rValid_reg <= 1'b0;
         rData_reg  <= 32'h00000000;
         rResp_reg  <= `PELR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_reg <= 1'b1;
         if (rSelHit) begin
            rData_reg <= {24'h000000, rSelByte};
            rResp_reg <= `PELR_RESP_OKAY;
         end else if (rStatHit) begin
            rData_reg <= statWord;
            rResp_reg <= `PELR_RESP_OKAY;
         end else begin
            rData_reg <= 32'h00000000;
            rResp_reg <= `PELR_RESP_SLVERR;
         end
      end else if (rValid_reg && s_axi_rready) begin
         rValid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------ selectors
   // a disabled selector drops its source's pulses outright
   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i = i + 1) begin : gSel
         // one selector per source, fed straight from the source pulse
         pelr_sel_reg uSel (
            .clk_sys   (clk_sys),
            .rstn      (rstn),
            .writeEn   (selWe[i]),
            .writeData (wData_reg[7:0]),
            .readData  (selRead[i*8 +: 8]),
            .eventIn   (srcEvent[i]),
            .routeAdc  (toAdc[i]),
            .routeDac0 (toDac0[i]),
            .routeDac1 (toDac1[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------ receivers
   // a/d trigger is combinational so the conversion starts on the event cycle
   assign adcConvStart = |toAdc;

   // reset empties the lag line so no stale start fires after reset
   // fixed two-cycle lag; an extra flop would still sit inside the window
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dac0Pipe_reg <= {LAG{1'b0}};
         dac1Pipe_reg <= {LAG{1'b0}};
      end else begin
         dac0Pipe_reg <= {dac0Pipe_reg[LAG-2:0], |toDac0};
         dac1Pipe_reg <= {dac1Pipe_reg[LAG-2:0], |toDac1};
      end
   end

   // lag counted in cpu clocks of this domain
   assign dacChannelZeroStart = dac0Pipe_reg[LAG-1];
   assign dacChannelOneStart  = dac1Pipe_reg[LAG-1];

   // ------------------------------------------------------------ status
   // live count of sources aimed at each receiver; flags misuse by software
   // counts saturate at two: only the presence of a clash matters
   always @* begin
      cntAdc  = 2'h0;
      cntDac0 = 2'h0;
      cntDac1 = 2'h0;
      for (k = 0; k < NUM_SRC; k = k + 1) begin
         if (selRead[k*8 +: 2] == `PELR_DEST_ADC && cntAdc != 2'h2) begin
            cntAdc = cntAdc + 2'h1;
         end
         if (selRead[k*8 +: 2] == `PELR_DEST_DAC0 && cntDac0 != 2'h2) begin
            cntDac0 = cntDac0 + 2'h1;
         end
         if (selRead[k*8 +: 2] == `PELR_DEST_DAC1 && cntDac1 != 2'h2) begin
            cntDac1 = cntDac1 + 2'h1;
         end
      end
      // flag order from the lowest bit: a/d, d/a 0, d/a 1
      clash = {cntDac1 == 2'h2, cntDac0 == 2'h2, cntAdc == 2'h2};
   end

   // sticky per-source routed flags; write one to clear, a new event wins
   // a pulse dropped by a disabled link leaves no flag behind
   always @* begin
      seen_next = seen_reg;
      if (doWrite && wStatHit) begin
         if (wStrb_reg[0]) begin
            seen_next[7:0] = seen_reg[7:0] & ~wData_reg[7:0];
         end
         if (wStrb_reg[1]) begin
            seen_next[9:8] = seen_reg[9:8] & ~wData_reg[9:8];
         end
      end
      seen_next = seen_next | (toAdc | toDac0 | toDac1);
   end

   // flags held here; cleared by reset or by a write of one
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         seen_reg <= 10'h000;
      end else begin
         seen_reg <= seen_next;
      end
   end

endmodule

// >>> verif/pelr_evt_src.sv
`timescale 1ns/1ps
module pelr_evt_src (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rstn,
   // launch request
   input  wire [9:0] fireReq,
   // event pulses
   output reg  [9:0] srcEvt
);
   // one-cycle pulses; bench never fires during a rewrite
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         srcEvt <= 10'h000;
      else
         srcEvt <= fireReq;
   end
endmodule

// >>> verif/pelr_router_asserts.sv
`timescale 1ns/1ps
module pelr_router_asserts (
   // clock and reset
   input wire        clk_sys,
   input wire        rstn,
   // register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // sources and triggers
   input wire        pinEdgeEvent0,
   input wire        pinEdgeEvent1,
   input wire        pinEdgeEvent2,
   input wire        pinEdgeEvent3,
   input wire        pinEdgeEvent4,
   input wire        pinEdgeEvent5,
   input wire        timerCh0EndEvent,
   input wire        timerCh1EndEvent,
   input wire        timerCh2EndEvent,
   input wire        timerCh3EndEvent,
   input wire        adcConvStart,
   input wire        dacChannelZeroStart,
   input wire        dacChannelOneStart
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // a trigger may only stem from some source
   wire anySrc = pinEdgeEvent0 | pinEdgeEvent1 | pinEdgeEvent2 | pinEdgeEvent3 | pinEdgeEvent4
               | pinEdgeEvent5 | timerCh0EndEvent | timerCh1EndEvent | timerCh2EndEvent | timerCh3EndEvent;
   // address and data taken at one edge
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_adc_direct:
      assert property (adcConvStart |-> anySrc) else $error("adc trigger without source");
   a_dac0_lag:
      assert property (dacChannelZeroStart |-> $past(anySrc, 2)) else $error("dac0 trigger off lag");
   a_dac1_lag:
      assert property (dacChannelOneStart |-> $past(anySrc, 2)) else $error("dac1 trigger off lag");
   a_wr_answer:
      assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
   a_b_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write answer dropped");
   a_rd_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_r_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data dropped");
   a_upper_zero:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:19] == 13'h0) else $error("upper bits set");
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "pelr_map.vh"
module tb_top;
   logic        clk_sys = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [9:0]  fireReq = 10'h000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [9:0]  srcEvt;
   wire         adcConvStart, dacChannelZeroStart, dacChannelOneStart;
   int          bad_count = 0, n_compared = 0;
   // byte address is four times the register index
   localparam logic [31:0] SEL = {10'h0, `PELR_IDX_SEL_FIRST, 2'h0};
   localparam logic [31:0] STAT = {10'h0, `PELR_IDX_STATUS, 2'h0};
   localparam logic [31:0] HOLE = STAT + 32'h4;
   localparam logic [1:0]  OK = `PELR_RESP_OKAY, ERR = `PELR_RESP_SLVERR;

   always #12.5 clk_sys = ~clk_sys;

   pelr_router dut (
      .clk_sys, .rstn,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .pinEdgeEvent0(srcEvt[0]), .pinEdgeEvent1(srcEvt[1]), .pinEdgeEvent2(srcEvt[2]),
      .pinEdgeEvent3(srcEvt[3]), .pinEdgeEvent4(srcEvt[4]), .pinEdgeEvent5(srcEvt[5]),
      .timerCh0EndEvent(srcEvt[6]), .timerCh1EndEvent(srcEvt[7]),
      .timerCh2EndEvent(srcEvt[8]), .timerCh3EndEvent(srcEvt[9]),
      .adcConvStart, .dacChannelZeroStart, .dacChannelOneStart
   );

   pelr_evt_src src (.clk_sys, .rstn, .fireReq, .srcEvt);

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // status expected after one pulse from source s alone
   function automatic logic [31:0] seen_exp(input int s, input logic [1:0] c);
      return (c == `PELR_DEST_OFF) ? 32'h0 : 32'h1 << s;
   endfunction

   // address and data offered together; each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ad, wd;
      ad = 0;
      wd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         ad |= s_axi_awvalid & s_axi_awready;
         wd |= s_axi_wvalid & s_axi_wready;
         if (ad) s_axi_awvalid <= 1'b0;
         if (wd) s_axi_wvalid <= 1'b0;
      end while (!(ad && wd));
      // late bready exercises the hold of the answer
      repeat ($urandom % 3) @(posedge clk_sys);
      s_axi_bready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom % 3) @(posedge clk_sys);
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask

   // fire sources; a/d seen in the pulse cycle, d/a two cycles on
   task automatic pulse(input logic [9:0] v, input int s, input logic [1:0] c);
      fireReq <= v;
      @(posedge clk_sys);
      fireReq <= 10'h000;
      #1;
      chk("adc", v[s] && c == `PELR_DEST_ADC, adcConvStart);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("dac0", v[s] && c == `PELR_DEST_DAC0, dacChannelZeroStart);
      chk("dac1", v[s] && c == `PELR_DEST_DAC1, dacChannelOneStart);
      @(posedge clk_sys);
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      int s;
      logic [31:0] d;
      void'($urandom(32'h493c9daf));
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 10; i++)
         rd(SEL + 4 * i, 32'h0, OK);
      rd(STAT, 32'h0, OK);
      wr(SEL, 32'hffffffff, OK);
      rd(SEL, 32'h3, OK);
      wr(HOLE, 32'h1, ERR);
      rd(HOLE, 32'h0, ERR);
      wr(SEL, 32'h0, OK);
      // lane 0 off: the selection register must keep its value
      s_axi_wstrb <= 4'he;
      wr(SEL, 32'h1, OK);
      s_axi_wstrb <= 4'hf;
      rd(SEL, 32'h0, OK);
      // one link at a time, so no receiver is shared
      for (int k = 0; k < 40; k++) begin
         s = $urandom % 10;
         d = $urandom;
         if (k < 4) d[1:0] = 2'(k);
         wr(SEL + 4 * s, d, OK);
         rd(SEL + 4 * s, {30'h0, d[1:0]}, OK);
         wr(STAT, 32'h3ff, OK);
         pulse(10'h1 << s, s, d[1:0]);
         rd(STAT, seen_exp(s, d[1:0]), OK);
         pulse(10'($urandom), s, d[1:0]);
         pulse(~(10'h1 << s), s, d[1:0]);
         wr(SEL + 4 * s, 32'h0, OK);
      end
      // reset in mid-run must drop a live link
      wr(SEL + 4 * 3, 32'h2, OK);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rd(SEL + 4 * 3, 32'h0, OK);
      pulse(10'h008, 3, `PELR_DEST_OFF);
      give_verdict();
   end

   // the run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      give_verdict();
   end
endmodule

bind pelr_router pelr_router_asserts chk_i (
   .clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pinEdgeEvent0, .pinEdgeEvent1,
   .pinEdgeEvent2, .pinEdgeEvent3, .pinEdgeEvent4, .pinEdgeEvent5, .timerCh0EndEvent,
   .timerCh1EndEvent, .timerCh2EndEvent, .timerCh3EndEvent, .adcConvStart,
   .dacChannelZeroStart, .dacChannelOneStart
);
